// File: hdl/ldc_consts.svh
// Register offsets, field positions and reset values of the regulator control block
`ifndef LDC_CONSTS_SVH
`define LDC_CONSTS_SVH
`define LDC_ADDR_FRONT_END     8'h8F
`define LDC_ADDR_ILIM          8'h94
`define LDC_ADDR_REG_CTRL      8'h90
`define LDC_ADDR_REG_VOLT      8'h91
`define LDC_ADDR_REG_FAULT     8'h92
`define LDC_RST_FRONT_END      8'h2B
`define LDC_RST_ILIM           8'h68
`define LDC_RST_REG_CTRL       8'h01
`define LDC_RST_REG_VOLT       8'h0F
`define LDC_RST_REG_FAULT      8'h02
`define LDC_FE_RO_MASK         8'h3F
`define LDC_ILIM_RW_MASK       8'hF8
`define LDC_CTRL_RW_MASK       8'h1F
`define LDC_VOLT_RW_MASK       8'h0F
`define LDC_FAULT_RW_MASK      8'h02
`define LDC_SYSMIN_MSB         7
`define LDC_SYSMIN_LSB         6
`define LDC_ILIM_MSB           7
`define LDC_ILIM_LSB           3
`define LDC_CTRL_EN            0
`define LDC_CTRL_STBY          1
`define LDC_CTRL_SLEEP         2
`define LDC_CTRL_LPWR          3
`define LDC_CTRL_SCP           4
`define LDC_FAULT_FLAG         0
`define LDC_FAULT_MASK         1
`define LDC_SYSMIN_RSVD        2'h3
`define LDC_ILIM_MAX_CODE      5'h14
`define LDC_PSTATE_STANDBY     2'h1
`define LDC_PSTATE_SLEEP       2'h2
`define LDC_VOLT_MSB           3
`define LDC_VOLT_LSB           0
`endif

// File: hdl/ldc_pkg.sv
// Types shared by the regulator control block
package ldc_pkg;
    typedef enum logic [1:0] {
        LDC_RUN,
        LDC_STANDBY,
        LDC_SLEEP
    } ldc_pstate_e;

    typedef struct packed {
        logic       on;
        logic       low_power;
        logic [3:0] voltage_code;
    } ldc_reg_drive_s;

    typedef struct packed {
        logic [1:0] sys_rail_min_code;
        logic [4:0] input_current_limit_code;
    } ldc_fe_drive_s;
endpackage

// File: hdl/ldc_ctrl.sv
// Regulator channel and front-end control registers behind a byte-wide register port
`timescale 1ns/1ps
`include "ldc_consts.svh"
module ldc_ctrl (
    input  wire logic                 REF_CLK,
    input  wire logic                 RST_N,
    input  wire logic                 WR_EN,
    input  wire logic                 RD_EN,
    input  wire logic [7:0]           ADDR,
    input  wire logic [7:0]           WDATA,
    output logic      [7:0]           RDATA,
    output logic                      RDATA_VALID,
    input  wire logic [1:0]           PMIC_STATE,
    input  wire logic                 OVERCURRENT,
    input  wire logic                 SYS_ABOVE_UPPER,
    input  wire logic                 SYS_BELOW_LOWER,
    output ldc_pkg::ldc_reg_drive_s   REG_DRIVE,
    output ldc_pkg::ldc_fe_drive_s    FE_DRIVE,
    output logic                      RTC_FROM_COIN_CELL,
    output logic                      FAULT_IRQ
);
    import ldc_pkg::*;

    // Pin-side inputs pass two flops before use
    logic [1:0] state_s1_ff, state_s2_ff;
    logic [2:0] pin_s1_ff, pin_s2_ff;

    logic [7:0] fe_ff, nxt_fe;
    logic [7:0] ilim_ff, nxt_ilim;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] volt_ff, nxt_volt;
    logic [7:0] fault_ff, nxt_fault;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       rvalid_ff, nxt_rvalid;
    logic       coin_ff, nxt_coin;
    logic       irq_ff, nxt_irq;
    ldc_reg_drive_s drive_ff, nxt_drive;
    ldc_pstate_e    pstate;
    logic           oc, above, below;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_s1_ff <= 2'h0;
            state_s2_ff <= 2'h0;
            pin_s1_ff   <= 3'h0;
            pin_s2_ff   <= 3'h0;
        end else begin
            state_s1_ff <= PMIC_STATE;
            state_s2_ff <= state_s1_ff;
            pin_s1_ff   <= {OVERCURRENT, SYS_ABOVE_UPPER, SYS_BELOW_LOWER};
            pin_s2_ff   <= pin_s1_ff;
        end
    end

    always_comb begin
        pstate = (state_s2_ff == `LDC_PSTATE_STANDBY) ? LDC_STANDBY :
                 (state_s2_ff == `LDC_PSTATE_SLEEP)   ? LDC_SLEEP : LDC_RUN;
        oc    = pin_s2_ff[2];
        above = pin_s2_ff[1];
        below = pin_s2_ff[0];
    end

    // Register writes and fault handling
    always_comb begin
        nxt_fe     = fe_ff;
        nxt_ilim   = ilim_ff;
        nxt_ctrl   = ctrl_ff;
        nxt_volt   = volt_ff;
        nxt_fault  = fault_ff;
        if (WR_EN) begin
            unique case (ADDR)
                // Reserved low bits of 0x8F keep their fixed values
                `LDC_ADDR_FRONT_END: nxt_fe = (WDATA & ~`LDC_FE_RO_MASK)
                                            | (fe_ff & `LDC_FE_RO_MASK);
                `LDC_ADDR_ILIM:      nxt_ilim = (WDATA & `LDC_ILIM_RW_MASK)
                                              | (ilim_ff & ~`LDC_ILIM_RW_MASK);
                `LDC_ADDR_REG_CTRL:  nxt_ctrl = WDATA & `LDC_CTRL_RW_MASK;
                `LDC_ADDR_REG_VOLT:  nxt_volt = WDATA & `LDC_VOLT_RW_MASK;
                // Flag clears by writing 1, mask is plain read/write
                `LDC_ADDR_REG_FAULT: begin
                    nxt_fault = (fault_ff & ~`LDC_FAULT_RW_MASK) | (WDATA & `LDC_FAULT_RW_MASK);
                    if (WDATA[`LDC_FAULT_FLAG]) begin
                        nxt_fault[`LDC_FAULT_FLAG] = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Overload sets the flag after any clear so the event is never lost
        if (oc) begin
            nxt_fault[`LDC_FAULT_FLAG] = 1'b1;
            // Hardware clear of the enable outranks a same-cycle software write
            if (ctrl_ff[`LDC_CTRL_SCP]) begin
                nxt_ctrl[`LDC_CTRL_EN] = 1'b0;
            end
        end
    end

    // Readback; unmapped addresses read as zero and RDATA holds until the next read
    always_comb begin
        nxt_rdata  = rdata_ff;
        nxt_rvalid = RD_EN;
        if (RD_EN) begin
            unique case (ADDR)
                `LDC_ADDR_FRONT_END: nxt_rdata = fe_ff;
                `LDC_ADDR_ILIM:      nxt_rdata = ilim_ff;
                `LDC_ADDR_REG_CTRL:  nxt_rdata = ctrl_ff;
                `LDC_ADDR_REG_VOLT:  nxt_rdata = volt_ff;
                `LDC_ADDR_REG_FAULT: nxt_rdata = fault_ff;
                default:             nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Operating mode decode against chip power state
    always_comb begin
        nxt_drive              = '0;
        nxt_drive.voltage_code = volt_ff[`LDC_VOLT_MSB:`LDC_VOLT_LSB];
        if (ctrl_ff[`LDC_CTRL_EN]) begin
            unique case (pstate)
                LDC_RUN: nxt_drive.on = 1'b1;
                LDC_STANDBY: begin
                    nxt_drive.on        = ctrl_ff[`LDC_CTRL_STBY];
                    nxt_drive.low_power = ctrl_ff[`LDC_CTRL_STBY] & ctrl_ff[`LDC_CTRL_LPWR];
                end
                LDC_SLEEP: begin
                    nxt_drive.on        = ctrl_ff[`LDC_CTRL_SLEEP];
                    nxt_drive.low_power = ctrl_ff[`LDC_CTRL_SLEEP] & ctrl_ff[`LDC_CTRL_LPWR];
                end
            endcase
        end
    end

    // Hysteresis: between thresholds the source holds
    always_comb begin
        nxt_coin = coin_ff;
        if (above) begin
            nxt_coin = 1'b0;
        end else if (below) begin
            nxt_coin = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            coin_ff <= 1'b0;
        end else begin
            coin_ff <= nxt_coin;
        end
    end

    // Masking gates only the output, so a masked fault can still be polled
    always_comb begin
        nxt_irq = fault_ff[`LDC_FAULT_FLAG] & ~fault_ff[`LDC_FAULT_MASK];
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fe_ff     <= `LDC_RST_FRONT_END;
            ilim_ff   <= `LDC_RST_ILIM;
            ctrl_ff   <= `LDC_RST_REG_CTRL;
            volt_ff   <= `LDC_RST_REG_VOLT;
            fault_ff  <= `LDC_RST_REG_FAULT;
            drive_ff  <= '0;
        end else begin
            fe_ff     <= nxt_fe;
            ilim_ff   <= nxt_ilim;
            ctrl_ff   <= nxt_ctrl;
            volt_ff   <= nxt_volt;
            fault_ff  <= nxt_fault;
            drive_ff  <= nxt_drive;
        end
    end

    // Reserved codes are passed through unchanged; software keeps clear of them
    ldc_fe_drive_s fe_drive_ff, nxt_fe_drive;
    always_comb begin
        nxt_fe_drive.sys_rail_min_code = fe_ff[`LDC_SYSMIN_MSB:`LDC_SYSMIN_LSB];
        nxt_fe_drive.input_current_limit_code = ilim_ff[`LDC_ILIM_MSB:`LDC_ILIM_LSB];
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fe_drive_ff <= '0;
        end else begin
            fe_drive_ff <= nxt_fe_drive;
        end
    end

    assign RDATA              = rdata_ff;
    assign RDATA_VALID        = rvalid_ff;
    assign REG_DRIVE          = drive_ff;
    assign FE_DRIVE           = fe_drive_ff;
    assign RTC_FROM_COIN_CELL = coin_ff;
    assign FAULT_IRQ          = irq_ff;
endmodule

// File: test/ldc_ctrl_checker.sv
// Concurrent checks on the ports of the regulator control block
`timescale 1ns/1ps
module ldc_ctrl_checker (
    input wire logic                 REF_CLK,
    input wire logic                 RST_N,
    input wire logic                 WR_EN,
    input wire logic                 RD_EN,
    input wire logic [7:0]           ADDR,
    input wire logic [7:0]           WDATA,
    input wire logic                 RDATA_VALID,
    input wire logic                 OVERCURRENT,
    input wire logic                 SYS_ABOVE_UPPER,
    input wire logic                 SYS_BELOW_LOWER,
    input wire ldc_pkg::ldc_reg_drive_s REG_DRIVE,
    input wire ldc_pkg::ldc_fe_drive_s  FE_DRIVE,
    input wire logic                 RTC_FROM_COIN_CELL,
    input wire logic                 FAULT_IRQ
);
    import ldc_pkg::*;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    chk_read_valid: assert property (RD_EN |=> RDATA_VALID) else $error("no valid");
    chk_valid_only: assert property (!RD_EN |=> !RDATA_VALID) else $error("stray");
    chk_volt_drive:
        assert property (WR_EN && ADDR == 8'h91 |-> ##2
            REG_DRIVE.voltage_code == $past(WDATA[3:0], 2)) else $error("volt");
    chk_ilim_drive:
        assert property (WR_EN && ADDR == 8'h94 |-> ##2
            FE_DRIVE.input_current_limit_code == $past(WDATA[7:3], 2)) else $error("ilim");
    chk_sysmin_drive:
        assert property (WR_EN && ADDR == 8'h8F |-> ##2
            FE_DRIVE.sys_rail_min_code == $past(WDATA[7:6], 2)) else $error("sysmin");
    chk_irq_cause:
        assert property ($rose(FAULT_IRQ) |-> $past(OVERCURRENT, 4) || $past(WR_EN, 2)
            || $past(WR_EN, 3)) else $error("irq cause");
    chk_rtc_rail:
        assert property (SYS_ABOVE_UPPER [*6] |-> !RTC_FROM_COIN_CELL) else $error("rail");
    chk_rtc_coin:
        assert property ((SYS_BELOW_LOWER && !SYS_ABOVE_UPPER) [*6] |-> RTC_FROM_COIN_CELL)
            else $error("coin");
    chk_rtc_hold:
        assert property ((!SYS_BELOW_LOWER && !SYS_ABOVE_UPPER) [*6] |->
            $stable(RTC_FROM_COIN_CELL)) else $error("hold");
    cov_read: cover property (RDATA_VALID);
    cov_fault: cover property (FAULT_IRQ);
    cov_coin: cover property (RTC_FROM_COIN_CELL);
    cov_low_power: cover property (REG_DRIVE.on && REG_DRIVE.low_power);
    cov_protect_off: cover property (FAULT_IRQ && !REG_DRIVE.on);
endmodule
bind ldc_ctrl ldc_ctrl_checker chk_u (.REF_CLK, .RST_N, .WR_EN, .RD_EN, .ADDR, .WDATA,
    .RDATA_VALID, .OVERCURRENT, .SYS_ABOVE_UPPER, .SYS_BELOW_LOWER, .REG_DRIVE, .FE_DRIVE,
    .RTC_FROM_COIN_CELL, .FAULT_IRQ);

// File: test/ldc_host_model.sv
// Processor model issuing single-byte register accesses
`timescale 1ns/1ps
module ldc_host_model (
    input  wire logic       clk,
    output logic            wr_en,
    output logic            rd_en,
    output logic [7:0]      addr,
    output logic [7:0]      wdata,
    input  wire logic [7:0] rdata,
    input  wire logic       rdata_valid
);
    initial begin
        {wr_en, rd_en, addr, wdata} = 18'h0;
    end
    // Idle buses show the inverse of the last value so stale data cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {wr_en, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        {wr_en, addr, wdata} <= {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        {rd_en, addr} <= {1'b1, a};
        @(posedge clk);
        {rd_en, addr} <= {1'b0, ~a};
        @(posedge clk);
        d = rdata;
        v = rdata_valid;
    endtask
endmodule

// File: test/ldc_ctrl_tb_top.sv
// Self-checking bench for the regulator control block
`timescale 1ns/1ps
module ldc_ctrl_tb_top;
    import ldc_pkg::*;
    logic clk, rst_n, oc, above, below, wr_en, rd_en, rdata_valid, rtc_coin, irq, v, eon, elp;
    logic [1:0] pstate;
    logic [7:0] addr, wdata, rdata, d;
    ldc_reg_drive_s reg_drive;
    ldc_fe_drive_s fe_drive;
    int mismatches, check_count, cycles;
    logic [7:0] ra [6] = '{8'h8F, 8'h94, 8'h90, 8'h91, 8'h92, 8'h93};
    logic [7:0] rv [6] = '{8'h2B, 8'h68, 8'h01, 8'h0F, 8'h02, 8'h00};
    ldc_ctrl dut_u (.REF_CLK(clk), .RST_N(rst_n), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
        .WDATA(wdata), .RDATA(rdata), .RDATA_VALID(rdata_valid), .PMIC_STATE(pstate),
        .OVERCURRENT(oc), .SYS_ABOVE_UPPER(above), .SYS_BELOW_LOWER(below),
        .REG_DRIVE(reg_drive), .FE_DRIVE(fe_drive), .RTC_FROM_COIN_CELL(rtc_coin),
        .FAULT_IRQ(irq));
    ldc_host_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .rdata_valid(rdata_valid));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, d, v);
        chk("valid", {7'h0, v}, 8'h01);
        chk("rdata", d, e);
    endtask
    // Overload lasts one cycle; the two-flop sync still catches it
    task automatic ovl;
        @(posedge clk);
        oc <= 1'b1;
        @(posedge clk);
        oc <= 1'b0;
        cyc(6);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        {rst_n, oc, above, below, pstate} = 6'h0;
        mismatches = 0;
        check_count = 0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(2);
        chk("fe", {1'b0, fe_drive}, 8'h0D);
        chk("reg", {2'h0, reg_drive}, 8'h2F);
        foreach (ra[i]) rc(ra[i], rv[i]);
        host_u.wr(8'h8F, 8'h80);
        host_u.wr(8'h94, 8'hA7);
        rc(8'h8F, 8'hAB);
        rc(8'h94, 8'hA0);
        chk("fe", {1'b0, fe_drive}, 8'h54);
        for (int i = 0; i < 16; i++) begin
            host_u.wr(8'h91, 8'(i));
            cyc(2);
            chk("volt", {4'h0, reg_drive.voltage_code}, 8'(i));
        end
        // State code 3 is decoded as Run, so it is swept with the others
        for (int s = 0; s < 4; s++) begin
            for (int b = 0; b < 16; b++) begin
                @(posedge clk);
                pstate <= 2'(s);
                host_u.wr(8'h90, 8'(b));
                cyc(4);
                eon = b[0] && (s == 0 || s == 3 || (s == 1 && b[1]) || (s == 2 && b[2]));
                elp = eon && (s == 1 || s == 2) && b[3];
                chk("on", {7'h0, reg_drive.on}, {7'h0, eon});
                chk("lp", {7'h0, reg_drive.low_power}, {7'h0, elp});
            end
        end
        @(posedge clk);
        pstate <= 2'h0;
        host_u.wr(8'h90, 8'h01);
        host_u.wr(8'h92, 8'h00);
        ovl();
        chk("irq", {7'h0, irq}, 8'h01);
        chk("on", {7'h0, reg_drive.on}, 8'h01);
        host_u.wr(8'h92, 8'h03);
        cyc(2);
        chk("irq", {7'h0, irq}, 8'h00);
        ovl();
        chk("irq", {7'h0, irq}, 8'h00);
        rc(8'h92, 8'h03);
        host_u.wr(8'h90, 8'h11);
        host_u.wr(8'h92, 8'h01);
        ovl();
        rc(8'h90, 8'h10);
        chk("on", {7'h0, reg_drive.on}, 8'h00);
        chk("irq", {7'h0, irq}, 8'h01);
        @(posedge clk);
        below <= 1'b1;
        cyc(7);
        chk("coin", {7'h0, rtc_coin}, 8'h01);
        @(posedge clk);
        below <= 1'b0;
        cyc(7);
        chk("coin", {7'h0, rtc_coin}, 8'h01);
        @(posedge clk);
        above <= 1'b1;
        cyc(7);
        chk("coin", {7'h0, rtc_coin}, 8'h00);
        final_report();
    end
endmodule
